//--- host_model.sv
// Host unit model: presses the detector reset request like a held button
`timescale 1ns/1ps
module host_model (
	input  wire i_clk,               // Clock
	input  wire i_go,                // Start one press
	output reg  o_host_reset = 1'b0  // Reset request level
);
	integer left = 0;  // Cycles of the press still to run
	// Hold ten cycles, since a glitch-length press proves nothing
	always @(posedge i_clk) begin
		left <= i_go ? 10 : (left > 0 ? left - 1 : 0);
		o_host_reset <= i_go || (left > 1);
	end
endmodule // host_model

//--- loop_detector.v
// Vehicle loop detector control: loop status, presence conditioning and status display
`timescale 1ns/1ps
`include "loop_detector_defines.vh"

module loop_detector #(
	parameter SEC_CYCLES = `SEC_CYCLES     // Cycles per second, shorten for simulation
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_nrst,
	// Host interconnect
	input  wire        i_host_reset,       // Reset request level from host unit
	output reg         o_presence,         // Vehicle presence to host
	// Configuration switch bank, bit 0 is switch 1, on = 1
	input  wire [7:0]  i_config_switch_bank,
	// Loop measurement results
	input  wire [15:0] i_ind_deviation,    // Inductance change from baseline, unsigned
	input  wire [1:0]  i_loop_health,      // 0 good .. 3 close to failure
	input  wire        i_conn_bad,         // Loop-to-board connection degraded
	input  wire        i_loop_open,        // Loop disconnected
	input  wire        i_ind_out_of_range, // Inductance outside operable range
	input  wire        i_board_fail,       // Board self-test failure
	// Status outputs
	output reg  [4:0]  o_display_code,     // Display symbol code
	output reg         o_display_dot,      // Decimal point
	output reg         o_conn_degraded,    // Distinct bad-connection flag
	output reg         o_weekly_log,       // 1 weekly, 0 daily logging
	output reg         o_booting           // Boot or blank phase active
);

	localparam ST_BLANK = 2'd0;            // Display dark after host reset
	localparam ST_BOOT  = 2'd1;            // Boot code shown
	localparam ST_RUN   = 2'd2;            // Normal operation

	// Twenty minutes at the full clock rate overflows 32 bits, so the timeout works in 36
	localparam [31:0] SEC_CYC_32  = SEC_CYCLES;
	localparam [35:0] SEC_CYC_W   = {4'h0, SEC_CYC_32};
	localparam [35:0] TIMEOUT_CYC = SEC_CYC_W * `TIMEOUT_MIN * 60;
	localparam [31:0] DIAG_CYC    = `DIAG_HALF_S * SEC_CYCLES;
	localparam [31:0] D6_CYC      = `DELAY_6_S * SEC_CYCLES;
	localparam [31:0] D4_CYC      = `DELAY_4_S * SEC_CYCLES;
	localparam [31:0] D2_CYC      = `DELAY_2_S * SEC_CYCLES;
	localparam [31:0] BLANK_CYC   = `BLANK_S * SEC_CYCLES;
	localparam [31:0] BOOT_CYC    = `BOOT_S * SEC_CYCLES;

	reg  [1:0]  state_reg;                 // Sequencer state
	reg  [31:0] seq_cnt_reg;               // Sequencer phase timer
	reg  [7:0]  sw_reg;                    // Latched switches
	reg         host_rst_d_reg;            // Host reset previous level
	reg         detect_reg;                // Raw detection with hysteresis
	reg  [31:0] dly_cnt_reg;               // Detection-to-signal delay timer
	reg  [35:0] hold_cnt_reg;              // Continuous presence timer, wide for 20 minutes
	reg         timed_out_reg;             // Presence cleared by timeout
	reg  [31:0] diag_cnt_reg;              // Diagnostic half-period timer
	reg         diag_on_reg;               // Diagnostic presence phase

	wire        running = (state_reg == ST_RUN);
	wire        host_rst_rise = i_host_reset & ~host_rst_d_reg;
	reg  [15:0] det_thr;                   // Detection threshold
	reg  [15:0] rel_thr;                   // Release threshold
	reg  [31:0] dly_cyc;                   // Selected delay in cycles
	reg  [4:0]  status_code;               // Combined loop status

	// Threshold and delay selection from latched switches
	always @* begin
		det_thr = sw_reg[`SW_LOW_SENS] ? `DET_LOW : `DET_NORMAL;
		case ({sw_reg[`SW_REL_HI], sw_reg[`SW_REL_LO]})
			2'b00:   rel_thr = `REL_LOW;   // Release only near baseline
			2'b01:   rel_thr = `REL_MED;
			2'b10:   rel_thr = `REL_HIGH;
			default: rel_thr = `REL_XHIGH; // Releases most readily
		endcase
		case ({sw_reg[`SW_DLY_HI], sw_reg[`SW_DLY_LO]})
			2'b00:   dly_cyc = D6_CYC;
			2'b01:   dly_cyc = D4_CYC;
			2'b10:   dly_cyc = D2_CYC;
			default: dly_cyc = 32'h0000_0000;
		endcase
	end

	// Loop status: faults outrank health grading
	always @* begin
		if (i_board_fail)
			status_code = `CODE_FAIL;
		else if (i_loop_open)
			status_code = `CODE_DISC;
		else if (i_ind_out_of_range)
			status_code = `CODE_RANGE;
		else
			// Grades 1..4, or 5..8 with a bad connection
			status_code = {3'b000, i_loop_health} + (i_conn_bad ? 5'h05 : 5'h01);
	end

	// Reset sequencer and switch capture
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg      <= ST_BOOT;     // Power-up starts with boot code
			seq_cnt_reg    <= 32'h0000_0000;
			sw_reg         <= `SW_RESET_VAL;
			host_rst_d_reg <= 1'b0;
		end else begin
			host_rst_d_reg <= i_host_reset;
			if (host_rst_rise) begin
				state_reg   <= ST_BLANK;
				seq_cnt_reg <= 32'h0000_0000;
			end else begin
				case (state_reg)
					ST_BLANK: begin
						if (seq_cnt_reg >= BLANK_CYC - 1) begin
							state_reg   <= ST_BOOT;
							seq_cnt_reg <= 32'h0000_0000;
						end else
							seq_cnt_reg <= seq_cnt_reg + 32'h0000_0001;
					end
					ST_BOOT: begin
						// Switches captured on leaving boot, after reset release
						if (seq_cnt_reg >= BOOT_CYC - 1) begin
							state_reg   <= ST_RUN;
							sw_reg      <= i_config_switch_bank;
							seq_cnt_reg <= 32'h0000_0000;
						end else
							seq_cnt_reg <= seq_cnt_reg + 32'h0000_0001;
					end
					ST_RUN:  seq_cnt_reg <= 32'h0000_0000;
					default: state_reg <= ST_BOOT;
				endcase
			end
		end
	end

	// Detection with hysteresis, delay, timeout and diagnostic cycling
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			detect_reg    <= 1'b0;
			dly_cnt_reg   <= 32'h0000_0000;
			hold_cnt_reg  <= 36'h0_0000_0000;
			timed_out_reg <= 1'b0;
			diag_cnt_reg  <= 32'h0000_0000;
			diag_on_reg   <= 1'b0;
			o_presence    <= 1'b0;
		end else if (!running) begin
			detect_reg    <= 1'b0;
			dly_cnt_reg   <= 32'h0000_0000;
			hold_cnt_reg  <= 36'h0_0000_0000;
			timed_out_reg <= 1'b0;
			diag_cnt_reg  <= 32'h0000_0000;
			diag_on_reg   <= 1'b1;
			o_presence    <= 1'b0;
		end else if (sw_reg[`SW_DIAG]) begin
			// Real detection suspended; fixed on/off cadence
			if (diag_cnt_reg >= DIAG_CYC - 1) begin
				diag_cnt_reg <= 32'h0000_0000;
				diag_on_reg  <= ~diag_on_reg;
			end else
				diag_cnt_reg <= diag_cnt_reg + 32'h0000_0001;
			o_presence <= diag_on_reg;
		end else begin
			// Set at or above detect threshold, clear below release threshold
			if (!detect_reg && i_ind_deviation >= det_thr)
				detect_reg <= 1'b1;
			else if (detect_reg && i_ind_deviation < rel_thr)
				detect_reg <= 1'b0;
			// Delay counts while detection persists
			if (!detect_reg) begin
				dly_cnt_reg   <= 32'h0000_0000;
				timed_out_reg <= 1'b0;     // Re-arm timeout once vehicle leaves
				hold_cnt_reg  <= 36'h0_0000_0000;
				o_presence    <= 1'b0;
			end else if (dly_cnt_reg < dly_cyc) begin
				dly_cnt_reg <= dly_cnt_reg + 32'h0000_0001;
			end else if (timed_out_reg) begin
				o_presence <= 1'b0;
			end else if (sw_reg[`SW_AUTO_RESET] && hold_cnt_reg >= TIMEOUT_CYC) begin
				timed_out_reg <= 1'b1;
				o_presence    <= 1'b0;
			end else begin
				o_presence   <= 1'b1;
				hold_cnt_reg <= hold_cnt_reg + 36'h0_0000_0001;
			end
		end
	end

	// Display and status outputs, all registered
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_display_code  <= `CODE_BOOT;
			o_display_dot   <= 1'b0;
			o_conn_degraded <= 1'b0;
			o_weekly_log    <= 1'b1;
			o_booting       <= 1'b1;
		end else begin
			case (state_reg)
				ST_BLANK: o_display_code <= `CODE_BLANK;
				ST_BOOT:  o_display_code <= `CODE_BOOT;
				default:  o_display_code <= status_code;
			endcase
			// Dot mirrors the presence flop, one cycle behind
			o_display_dot   <= o_presence;
			// Raised independently of the health grade
			o_conn_degraded <= i_conn_bad & ~i_loop_open;
			o_weekly_log    <= sw_reg[`SW_WEEKLY];
			o_booting       <= ~running;
		end
	end

endmodule // loop_detector

//--- loop_detector_asserts.sv
// Port checker for the loop detector control
`timescale 1ns/1ps
`include "loop_detector_defines.vh"
module loop_detector_asserts #(parameter SEC_CYCLES = 10) (
	input wire       i_clk, i_nrst, i_host_reset, i_conn_bad, i_loop_open, i_board_fail,
	input wire       i_ind_out_of_range, o_presence, o_display_dot, o_conn_degraded, o_weekly_log, o_booting,
	input wire [1:0] i_loop_health,
	input wire [4:0] o_display_code
);
	localparam int BOOT_MAX = 2 * SEC_CYCLES + 4;  // Boot span with margin for lag
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// Settled run: no boot and no fresh host press in the last two cycles
	sequence s_run;
		!o_booting && !$past(o_booting) && !$past(i_host_reset) && !$past(i_host_reset, 2);
	endsequence
	property p_dot; $past(i_nrst) |-> o_display_dot == $past(o_presence); endproperty
	a_dot: assert property (p_dot) else $error("dot not following presence");
	property p_conn; $past(i_nrst) |-> o_conn_degraded == $past(i_conn_bad & ~i_loop_open); endproperty
	a_conn: assert property (p_conn) else $error("bad connection flag wrong");
	property p_fail; s_run ##0 $past(i_board_fail) |-> o_display_code == `CODE_FAIL; endproperty
	a_fail: assert property (p_fail) else $error("failure code missing");
	property p_disc; s_run ##0 $past(!i_board_fail && i_loop_open) |-> o_display_code == `CODE_DISC; endproperty
	a_disc: assert property (p_disc) else $error("disconnect code missing");
	property p_health;
		s_run ##0 $past(!i_board_fail && !i_loop_open && !i_ind_out_of_range) |->
			o_display_code == 5'h01 + $past(i_loop_health) + ($past(i_conn_bad) ? 5'h04 : 5'h00);
	endproperty
	a_health: assert property (p_health) else $error("health code wrong");
	property p_boot; $rose(i_nrst) |-> (o_booting && o_display_code == `CODE_BOOT)[*8] ##[1:BOOT_MAX] !o_booting; endproperty
	a_boot: assert property (p_boot) else $error("boot phase wrong");
	property p_host; $rose(i_host_reset) && !o_booting |-> ##[1:2] (o_display_code == `CODE_BLANK)[*8]; endproperty
	a_host: assert property (p_host) else $error("host reset not blanking");
	property p_week; !o_booting && !$past(o_booting) |-> $stable(o_weekly_log); endproperty
	a_week: assert property (p_week) else $error("log period changed in run");
	c_pres: cover property ($rose(o_presence));
	c_host: cover property ($rose(i_host_reset));
	c_conn: cover property ($rose(o_conn_degraded));
endmodule // loop_detector_asserts
bind loop_detector loop_detector_asserts #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
	.i_host_reset(i_host_reset), .i_conn_bad(i_conn_bad), .i_loop_open(i_loop_open), .i_board_fail(i_board_fail),
	.i_ind_out_of_range(i_ind_out_of_range), .o_presence(o_presence), .o_display_dot(o_display_dot),
	.o_conn_degraded(o_conn_degraded), .o_weekly_log(o_weekly_log), .o_booting(o_booting),
	.i_loop_health(i_loop_health), .o_display_code(o_display_code));

//--- loop_detector_defines.vh
// Timing counts, switch positions and display codes of the loop detector control
`ifndef LOOP_DETECTOR_DEFINES_VH
`define LOOP_DETECTOR_DEFINES_VH
`define CLK_HZ            40000000
`define TIMEOUT_MIN       20
`define DIAG_HALF_S       10
`define DELAY_6_S         6
`define DELAY_4_S         4
`define DELAY_2_S         2
`define BLANK_S           3
`define BOOT_S            2
`define SEC_CYCLES        (`CLK_HZ)
`define SW_AUTO_RESET     0
`define SW_LOW_SENS       1
`define SW_REL_HI         2
`define SW_REL_LO         3
`define SW_DIAG           4
`define SW_DLY_HI         5
`define SW_DLY_LO         6
`define SW_WEEKLY         7
`define SW_RESET_VAL      8'hE9
`define CODE_BLANK        5'h00
`define CODE_HEALTHY      5'h10
`define CODE_BOOT         5'h0B
`define CODE_DISC         5'h0D
`define CODE_RANGE        5'h1C
`define CODE_FAIL         5'h0F
`define DET_NORMAL        16'h0040
`define DET_LOW           16'h0080
`define REL_LOW           16'h0010
`define REL_MED           16'h0020
`define REL_HIGH          16'h0030
`define REL_XHIGH         16'h0038
`endif

//--- tb_top.sv
// Self-checking bench for the loop detector control
`timescale 1ns/1ps
`include "loop_detector_defines.vh"
module tb_top;
	reg        i_clk = 0, i_nrst = 0, go = 0;     // Clock, reset, host press start
	reg  [7:0] sw = 8'hE9;                        // Switch bank
	reg [15:0] dev = 16'h0000, det, relt;         // Deviation and its thresholds
	reg  [1:0] hl = 2'h0;                         // Loop health
	reg        cb = 0, op = 0, rg = 0, bf = 0;    // Fault inputs
	wire       hr, pr, dot, cd, wk, bt;           // Design outputs
	wire [4:0] code;                              // Display code
	integer    error_cnt = 0, n_checks = 0, n, i, e;
	always #12.5 i_clk = ~i_clk;
	host_model u_host (.i_clk(i_clk), .i_go(go), .o_host_reset(hr));
	loop_detector #(.SEC_CYCLES(10)) u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_host_reset(hr), .o_presence(pr),
		.i_config_switch_bank(sw), .i_ind_deviation(dev), .i_loop_health(hl), .i_conn_bad(cb), .i_loop_open(op),
		.i_ind_out_of_range(rg), .i_board_fail(bf), .o_display_code(code), .o_display_dot(dot),
		.o_conn_degraded(cd), .o_weekly_log(wk), .o_booting(bt));
	task stop_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string s, input [15:0] x, input [15:0] v);
		n_checks = n_checks + 1;
		if (v !== x) begin
			error_cnt = error_cnt + 1;
			$display("BAD %s expected %0h seen %0h", s, x, v);
		end
	endtask
	task cyc(input integer k); repeat (k) @(posedge i_clk); endtask
	// Count cycles until presence shows the wanted level
	task wp(input v, input integer lim);
		n = 0;
		while (pr !== v && n < lim) begin cyc(1); n = n + 1; end
	endtask
	// Reset with a switch setting; switches are latched at boot end
	task rst(input [7:0] s);
		sw <= s; i_nrst <= 0; cyc(10);
		chk("reset code", `CODE_BOOT, code);
		i_nrst <= 1; cyc(30);
		chk("booting", 0, bt);
	endtask
	initial begin
		rst(8'hE9);
		chk("weekly", 1, wk);
		for (i = 0; i < 8; i = i + 1) begin
			hl <= i[1:0]; cb <= i[2]; cyc(3);
			chk("health", i + 1, code);
			chk("conn", i[2], cd);
		end
		op <= 1; cyc(3);
		chk("disc", `CODE_DISC, code);
		chk("conn open", 0, cd);
		rg <= 1; bf <= 1; cyc(3);
		chk("fail", `CODE_FAIL, code);
		bf <= 0; op <= 0; cyc(3);
		chk("range", `CODE_RANGE, code);
		rg <= 0; cb <= 0; hl <= 0;
		// Each pass sets its own sensitivity, release and delay
		for (i = 0; i < 4; i = i + 1) begin
			rst({i[1], i[0], i[1], 1'b0, i[0], i[1], i[0], 1'b0});
			chk("weekly", i[1], wk);
			det = i[0] ? `DET_LOW : `DET_NORMAL;
			relt = (i == 3) ? 16'h38 : 16'h10 * (i + 1);
			e = 3 + (3 - i) * 20;
			dev <= det - 1; cyc(80);
			chk("below detect", 0, pr);
			dev <= det; wp(1, 100);
			chk("delay", 1, n >= e - 1 && n <= e + 1);
			dev <= relt; cyc(5);
			chk("hold", 1, pr);
			chk("dot on", 1, dot);
			dev <= relt - 1; cyc(4);
			chk("release", 0, pr);
			chk("dot off", 0, dot);
		end
		rst(8'hE9);
		dev <= `DET_NORMAL; wp(1, 10); wp(0, 12100);
		chk("timeout", 1, n >= 11998 && n <= 12002);
		cyc(20);
		chk("timeout stays", 0, pr);
		rst(8'hF9);
		// The run cycles inside the reset wait eat part of the first on phase, so time whole phases after it
		dev <= 0; wp(0, 200); wp(1, 200);
		chk("diag off", 1, n >= 99 && n <= 101);
		wp(0, 200);
		chk("diag on", 1, n >= 99 && n <= 101);
		rst(8'hE9);
		go <= 1; cyc(1); go <= 0; cyc(4);
		chk("host blank", `CODE_BLANK, code);
		cyc(30);
		chk("host boot", `CODE_BOOT, code);
		cyc(25);
		chk("host run", 0, bt);
		chk("host code", 1, code);
		stop_test;
	end
	// Watchdog well past the expected run length
	initial begin
		#(25 * 40000);
		error_cnt = error_cnt + 1;
		stop_test;
	end
endmodule // tb_top
